// ### hw/error_queue.v
// Purpose: first-in first-out store of error codes for readback
// Assumes: push and pop are one-cycle pulses on core_clk
// Notes:   a push into a full queue is dropped and flags overflow
`timescale 1ns/1ps
`default_nettype none

module error_queue
#(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
)
(
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // producer side
  input wire push,
  input wire [WIDTH-1:0] push_code,
  // consumer side
  input wire pop,
  output wire [WIDTH-1:0] head_code,
  output wire not_empty,
  output reg overflow
);

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // stored codes
  reg [AW-1:0] wr_ptr; // next free slot
  reg [AW-1:0] rd_ptr; // oldest entry
  reg [AW:0] count; // entries held
  wire full; // no room left
  wire do_push; // push that is really stored
  wire do_pop; // pop of a real entry

  assign full = (count == DEPTH[AW:0]);
  assign not_empty = (count != {(AW+1){1'b0}});
  assign do_push = push & ~full;
  assign do_pop = pop & not_empty;
  assign head_code = mem[rd_ptr];

  ////////////////////////////////////////////////////////////////////////
  // storage: no reset, the count alone says what is valid
  always @(posedge core_clk)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= push_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pointers, count and sticky overflow (cleared by a pop)
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      overflow <= 1'b0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : wr_ptr + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
      // a lost entry must win over a pop in the same cycle
      if (push & full)
      begin
        overflow <= 1'b1;
      end
      else if (do_pop)
      begin
        overflow <= 1'b0;
      end
    end
  end

endmodule // error_queue

`default_nettype wire

// ### hw/remote_status_sync_unit.v
// Purpose: status reporting and command sync of a remote-controlled
//          instrument, with registers reached over apb
// Assumes: command parser and output unit sit outside and use the
//          instrument-side ports; apb is synchronous to core_clk
// Notes:   one wait state on every apb access
`timescale 1ns/1ps
`default_nettype none
`include "status_sync_defines.vh"

module remote_status_sync_unit
#(
  parameter ERRQ_DEPTH = 8,
  parameter ERRQ_AW = 3
)
(
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // instrument side: execution and output buffer state
  input wire exec_busy,
  input wire out_buf_avail,
  input wire out_data_pending,
  // instrument side: bus events
  input wire talker_addressed,
  input wire query_abort,
  input wire serial_poll,
  // instrument side: errors and other standard events
  input wire err_post,
  input wire [15:0] err_code,
  input wire [7:1] evt_in,
  // results toward the bus interface and parser
  output wire srq,
  output wire ist,
  output reg hold_exec,
  output reg opc_reply
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  // software-visible masks and event register
  reg [7:0] sre; // service request enable
  reg [7:0] ese; // event status enable
  reg [7:0] ppe; // parallel poll enable
  reg [7:0] esr; // standard event register, read clears
  // synchronisation state
  reg opc_pending; // operation-complete command waiting
  reg opcq_pending; // operation-complete query waiting
  reg wai_pending; // wait command holding execution
  // next values
  reg [7:0] next_esr;
  reg next_opc_pending;
  reg next_opcq_pending;
  reg next_wai_pending;
  reg next_opc_reply;
  reg [31:0] next_prdata;
  reg next_pslverr;
  // error queue feed
  reg err_push; // one error into the queue
  reg [15:0] err_push_code; // code of that error
  wire [15:0] errq_head; // oldest queued code
  wire errq_not_empty; // queue holds an entry
  wire errq_overflow; // an error was lost
  wire [7:0] stb; // status byte from the summary block
  // apb decode
  wire apb_setup_done; // access phase waiting for our answer
  wire apb_commit; // edge at which the master samples pready
  wire wr_commit; // write takes effect now
  wire rd_commit; // read data is taken now
  wire addr_known; // address hits a register
  wire cmd_opc; // operation-complete command written
  wire cmd_opcq; // operation-complete query written
  wire cmd_wai; // wait command written
  wire empty_talk; // talker with nothing to say
  wire abort_hit; // pending query interrupted

  ////////////////////////////////////////////////////////////////////////
  // apb handshake terms

  assign apb_setup_done = psel & penable & ~pready;
  assign apb_commit = psel & penable & pready;
  assign wr_commit = apb_commit & pwrite;
  assign rd_commit = apb_commit & ~pwrite;
  assign addr_known = (paddr == `ADDR_STB) | (paddr == `ADDR_SRE) |
                      (paddr == `ADDR_ESR) | (paddr == `ADDR_ESE) |
                      (paddr == `ADDR_PPE) | (paddr == `ADDR_CMD) |
                      (paddr == `ADDR_ERRQ) | (paddr == `ADDR_SYNC);

  // command strobes, all non-blocking for the parser unless it syncs
  assign cmd_opc = wr_commit & (paddr == `ADDR_CMD) & pwdata[`CMD_OPC];
  assign cmd_opcq = wr_commit & (paddr == `ADDR_CMD) & pwdata[`CMD_OPCQ];
  assign cmd_wai = wr_commit & (paddr == `ADDR_CMD) & pwdata[`CMD_WAI];

  // a pending opc query counts as data awaited from the database
  assign empty_talk = talker_addressed & ~out_buf_avail &
                      ~out_data_pending & ~opcq_pending;
  assign abort_hit = query_abort & opcq_pending;

  ////////////////////////////////////////////////////////////////////////
  // error source selection: own errors first; a colliding external
  // error is dropped, the parser must retry when that matters
  always @*
  begin
    err_push = 1'b0;
    err_push_code = 16'h0000;
    if (empty_talk)
    begin
      err_push = 1'b1;
      err_push_code = `ERR_QUERY_UNTERMINATED;
    end
    else if (abort_hit)
    begin
      err_push = 1'b1;
      err_push_code = `ERR_QUERY_INTERRUPTED;
    end
    else if (err_post)
    begin
      err_push = 1'b1;
      err_push_code = err_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // synchronisation sequencer and standard event register
  always @*
  begin
    next_opc_pending = opc_pending | cmd_opc;
    next_opcq_pending = opcq_pending | cmd_opcq;
    next_wai_pending = wai_pending | cmd_wai;
    next_opc_reply = 1'b0;
    next_esr = esr;
    // reading clears only the bits shown; events below still set
    if (rd_commit & (paddr == `ADDR_ESR))
    begin
      next_esr = esr & ~prdata[7:0];
    end
    next_esr[7:1] = next_esr[7:1] | evt_in;
    // completion waits for the earlier commands and for settling
    if (~exec_busy)
    begin
      if (opc_pending)
      begin
        next_esr[`ESR_OPC] = 1'b1;
        next_opc_pending = cmd_opc;
      end
      if (opcq_pending)
      begin
        next_esr[`ESR_OPC] = 1'b1;
        next_opc_reply = 1'b1;
        next_opcq_pending = cmd_opcq;
      end
      if (wai_pending)
      begin
        next_wai_pending = cmd_wai;
      end
    end
    // an interrupted query gives up its reply
    if (abort_hit)
    begin
      next_opc_reply = 1'b0;
      next_opcq_pending = cmd_opcq;
    end
  end

  // registers of the sequencer; hold is only raised by sync commands,
  // so every other command runs overlapped
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      esr <= 8'h00;
      opc_pending <= 1'b0;
      opcq_pending <= 1'b0;
      wai_pending <= 1'b0;
      opc_reply <= 1'b0;
      hold_exec <= 1'b0;
    end
    else
    begin
      esr <= next_esr;
      opc_pending <= next_opc_pending;
      opcq_pending <= next_opcq_pending;
      wai_pending <= next_wai_pending;
      opc_reply <= next_opc_reply;
      // apb stays open while held, so messages keep arriving
      hold_exec <= next_opcq_pending | next_wai_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mask registers written by software
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sre <= `MASK_RST;
      ese <= `MASK_RST;
      ppe <= `MASK_RST;
    end
    else if (wr_commit)
    begin
      case (paddr)
        `ADDR_SRE: sre <= pwdata[7:0];
        `ADDR_ESE: ese <= pwdata[7:0];
        `ADDR_PPE: ppe <= pwdata[7:0];
        default: sre <= sre;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data mux, sampled one cycle before the master takes it
  always @*
  begin
    next_prdata = 32'h0000_0000;
    next_pslverr = ~addr_known;
    case (paddr)
      `ADDR_STB: next_prdata[7:0] = stb;
      `ADDR_SRE: next_prdata[7:0] = sre;
      `ADDR_ESR: next_prdata[7:0] = esr;
      `ADDR_ESE: next_prdata[7:0] = ese;
      `ADDR_PPE: next_prdata[7:0] = ppe;
      `ADDR_ERRQ:
      begin
        // code reads as zero when nothing is queued
        next_prdata[15:0] = errq_not_empty ? errq_head : 16'h0000;
        next_prdata[`ERRQ_VALID] = errq_not_empty;
        next_prdata[`ERRQ_OVFL] = errq_overflow;
      end
      `ADDR_SYNC:
      begin
        next_prdata[`SYNC_HOLD] = hold_exec;
        next_prdata[`SYNC_OPC] = opc_pending;
        next_prdata[`SYNC_OPCQ] = opcq_pending;
        next_prdata[`SYNC_WAI] = wai_pending;
        next_prdata[`SYNC_IST] = ist;
      end
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // apb answer: pready one cycle after the access phase opens
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (apb_setup_done)
    begin
      pready <= 1'b1;
      pslverr <= next_pslverr;
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // error queue: the committed read of its word removes the entry
  error_queue
  #(
    .WIDTH(16),
    .DEPTH(ERRQ_DEPTH),
    .AW(ERRQ_AW)
  )
  u_error_queue
  (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .push(err_push),
    .push_code(err_push_code),
    .pop(rd_commit & (paddr == `ADDR_ERRQ) & prdata[`ERRQ_VALID]),
    .head_code(errq_head),
    .not_empty(errq_not_empty),
    .overflow(errq_overflow)
  );

  ////////////////////////////////////////////////////////////////////////
  // status byte, service request and individual status
  status_summary u_status_summary
  (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .esr(esr),
    .ese(ese),
    .sre(sre),
    .ppe(ppe),
    .mav(out_buf_avail),
    .errq_not_empty(errq_not_empty),
    .poll_clear(serial_poll),
    .stb(stb),
    .srq(srq),
    .ist(ist)
  );

endmodule // remote_status_sync_unit

`default_nettype wire

// ### hw/status_summary.v
// Purpose: status byte, service request and individual status flag
// Assumes: all inputs synchronous to core_clk
// Notes:   outputs are registered, one cycle behind their causes
`timescale 1ns/1ps
`default_nettype none
`include "status_sync_defines.vh"

module status_summary
(
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // sources
  input wire [7:0] esr,
  input wire [7:0] ese,
  input wire [7:0] sre,
  input wire [7:0] ppe,
  input wire mav,
  input wire errq_not_empty,
  input wire poll_clear,
  // results
  output reg [7:0] stb,
  output reg srq,
  output reg ist
);

  reg [7:0] prev_sum; // summary bits of the last cycle
  reg [7:0] sum_now; // summary bits without the request bit
  reg [7:0] sre_eff; // service enable with bit 6 forced off
  reg [7:0] rise; // enabled bits that went 0 to 1
  reg next_srq; // request latch next value
  reg [7:0] next_stb; // full status byte next value

  ////////////////////////////////////////////////////////////////////////
  // compose the status byte and find enabled rising bits
  always @*
  begin
    sum_now = 8'h00;
    sum_now[`STB_ERRQ] = errq_not_empty;
    sum_now[`STB_MAV] = mav;
    sum_now[`STB_ESB] = |(esr & ese);
    sre_eff = sre;
    sre_eff[`STB_MSS] = 1'b0;
    rise = sum_now & ~prev_sum & sre_eff;
    // a new request wins over a poll clearing the old one
    next_srq = (srq & ~poll_clear) | (|rise);
    next_stb = sum_now;
    next_stb[`STB_MSS] = next_srq;
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      prev_sum <= 8'h00;
      stb <= 8'h00;
      srq <= 1'b0;
      ist <= 1'b0;
    end
    else
    begin
      prev_sum <= sum_now;
      stb <= next_stb;
      srq <= next_srq;
      // bit 6 takes part here, unlike the service enable
      ist <= |(next_stb & ppe);
    end
  end

endmodule // status_summary

`default_nettype wire

// ### hw/status_sync_defines.vh
// Purpose: shared constants of the remote status and sync unit
// Assumes: included by bare name from the unit, the summary block and the bench, not the error queue
// Notes:   definitions only, no logic
`ifndef STATUS_SYNC_DEFINES_VH
`define STATUS_SYNC_DEFINES_VH

////////////////////////////////////////////////////////////////////////////
// register byte addresses on the apb (8-bit address space)
`define ADDR_STB 8'h00
`define ADDR_SRE 8'h04
`define ADDR_ESR 8'h08
`define ADDR_ESE 8'h0c
`define ADDR_PPE 8'h10
`define ADDR_CMD 8'h14
`define ADDR_ERRQ 8'h18
`define ADDR_SYNC 8'h1c

////////////////////////////////////////////////////////////////////////////
// status byte field positions
`define STB_ERRQ 2
`define STB_MAV 4
`define STB_ESB 5
`define STB_MSS 6

// standard event register: operation complete bit
`define ESR_OPC 0

// command register bits (write one to trigger)
`define CMD_OPC 0
`define CMD_OPCQ 1
`define CMD_WAI 2

// sync status register bits
`define SYNC_HOLD 0
`define SYNC_OPC 1
`define SYNC_OPCQ 2
`define SYNC_WAI 3
`define SYNC_IST 4

// error queue read word: code in low half, flags above
`define ERRQ_VALID 16
`define ERRQ_OVFL 17

////////////////////////////////////////////////////////////////////////////
// reset values and error codes (16-bit two's complement)
`define MASK_RST 8'h00
`define ERR_QUERY_INTERRUPTED 16'hfe66
`define ERR_QUERY_UNTERMINATED 16'hfe5c

`endif

// ### verification/instr_model.sv
// Purpose: behavioural instrument core behind the status unit
// Assumes: start and fetch are one-cycle pulses from the bench
// Notes:   answer data counts as awaited while the core settles
`timescale 1ns/1ps
`default_nettype none
module instr_model
#(
  parameter int BUSY_LEN = 12
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // bench controls and unit reply
  input wire logic start,
  input wire logic fetch,
  input wire logic opc_reply,
  // status toward the unit
  output var logic exec_busy,
  output var logic out_buf_avail,
  output var logic out_data_pending
);
  int cnt; // settling cycles left
  initial {exec_busy, out_buf_avail, out_data_pending} = 3'h0;
  ////////////////////////////////////////////////////////////////////////
  // settling timer and buffer, changed just after each edge
  always @(posedge core_clk)
  begin
    if (sys_rst)
      cnt <= 0;
    else if (start)
      cnt <= BUSY_LEN; // a new setting restarts the settle time
    else if (cnt != 0)
      cnt <= cnt - 1;
    exec_busy <= !sys_rst && (start || cnt > 1);
    if (sys_rst || fetch)
      out_buf_avail <= 1'b0; // controller read the answer
    else if (opc_reply)
      out_buf_avail <= 1'b1; // the "1" answer lands here
    out_data_pending <= !sys_rst && (start || cnt > 1); // awaited
  end
endmodule // instr_model
`default_nettype wire

// ### verification/remote_status_sync_unit_test.sv
// Purpose: self-checking bench of the status and sync unit
// Assumes: apb master drives after each edge; model plays the core
// Notes:   expected read data is queued, checked when the answer comes
`timescale 1ns/1ps
`default_nettype none
`include "status_sync_defines.vh"
module remote_status_sync_unit_test;
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic exec_busy, out_buf_avail, out_data_pending;
  logic srq, ist, hold_exec, opc_reply;
  logic [5:0] ev; // one-cycle event pulses
  logic [15:0] err_code, seed;
  logic [7:1] evt_in;
  logic [7:0] mk[3] = '{`ADDR_SRE, `ADDR_ESE, `ADDR_PPE};
  logic [32:0] expq[$]; // expected {error, read word}, oldest first
  int failures, n_checks, cycles;
  localparam logic [5:0] TALK = 6'h01, ABORT = 6'h02, POLL = 6'h04;
  localparam logic [5:0] ERR = 6'h08, GO = 6'h10, FETCH = 6'h20;
  ////////////////////////////////////////////////////////////////////////
  remote_status_sync_unit dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .exec_busy(exec_busy), .out_buf_avail(out_buf_avail),
    .out_data_pending(out_data_pending), .talker_addressed(ev[0]),
    .query_abort(ev[1]), .serial_poll(ev[2]), .err_post(ev[3]),
    .err_code(err_code), .evt_in(evt_in), .srq(srq), .ist(ist),
    .hold_exec(hold_exec), .opc_reply(opc_reply));
  instr_model core_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .start(ev[4]),
    .fetch(ev[5]), .opc_reply(opc_reply), .exec_busy(exec_busy),
    .out_buf_avail(out_buf_avail), .out_data_pending(out_data_pending));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // compare one read word
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask
  // one apb transfer; held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      expq.push_back({a > `ADDR_SYNC, d}); // unmapped reads answer an error
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk); // one idle edge between transfers
  endtask
  // one-cycle pulse on event lines and standard events
  task automatic pulse(input logic [5:0] m, input logic [7:1] e);
    ev <= m;
    evt_in <= e;
    @(posedge core_clk);
    ev <= 6'h0;
    evt_in <= 7'h0;
  endtask
  task automatic waitn(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic results;
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // clock of 100 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // answer watcher: oldest note against each read answer
  always @(posedge core_clk)
    if (psel && penable && pready && !pwrite)
      chk({pslverr, prdata}, expq.pop_front());
  // a hung wait ends on the bench's own limit
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      results();
    end
  end
  // main sequence
  initial
  begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {ev, err_code, evt_in} = 29'h0;
    seed = 16'h33fb; // 13307
    waitn(2);
    sys_rst <= 1'b0;
    waitn(1);
    // masks clear at reset and hold any eight-bit value
    foreach (mk[i])
    begin
      seed = lfsr(seed);
      xfer(0, mk[i], 32'h0);
      xfer(1, mk[i], {24'h0, seed[7:0]});
      xfer(0, mk[i], {24'h0, seed[7:0]});
      xfer(1, mk[i], 32'h0);
    end
    xfer(0, 8'h20, 32'h0);
    // talking with an empty buffer queues an error
    pulse(TALK, 7'h0);
    waitn(3);
    xfer(0, `ADDR_STB, 32'h4);
    xfer(0, `ADDR_ERRQ, {15'h0, 1'b1, `ERR_QUERY_UNTERMINATED});
    xfer(0, `ADDR_ERRQ, 32'h0);
    seed = lfsr(seed);
    err_code <= seed;
    pulse(ERR, 7'h0);
    xfer(0, `ADDR_ERRQ, {15'h0, 1'b1, seed});
    // completion signalled by service request on the event summary
    xfer(1, `ADDR_ESE, 32'h1);
    xfer(1, `ADDR_SRE, 32'h20);
    pulse(GO, 7'h0);
    xfer(1, `ADDR_CMD, 32'h1);
    while (!srq)
      @(posedge core_clk);
    xfer(0, `ADDR_STB, 32'h60);
    xfer(0, `ADDR_ESR, 32'h1);
    waitn(3);
    xfer(0, `ADDR_STB, 32'h40);
    pulse(POLL, 7'h0);
    waitn(3);
    xfer(0, `ADDR_STB, 32'h0);
    seed = lfsr(seed);
    pulse(6'h0, seed[7:1]);
    xfer(0, `ADDR_ESR, {24'h0, seed[7:1], 1'b0});
    // query completion through message available
    xfer(1, `ADDR_ESE, 32'h0);
    xfer(1, `ADDR_SRE, 32'h10);
    xfer(1, `ADDR_PPE, 32'h10);
    pulse(GO, 7'h0);
    xfer(1, `ADDR_CMD, 32'h2);
    xfer(0, `ADDR_SYNC, 32'h5);
    while (!srq)
      @(posedge core_clk);
    waitn(2);
    xfer(0, `ADDR_STB, 32'h50);
    xfer(0, `ADDR_SYNC, 32'h10);
    pulse(FETCH | POLL, 7'h0);
    waitn(3);
    xfer(0, `ADDR_STB, 32'h0);
    // an interrupted query cancels its answer and logs an error
    xfer(1, `ADDR_SRE, 32'h0);
    pulse(GO, 7'h0);
    xfer(1, `ADDR_CMD, 32'h2);
    pulse(ABORT, 7'h0);
    xfer(0, `ADDR_SYNC, 32'h0);
    xfer(0, `ADDR_ERRQ, {15'h0, 1'b1, `ERR_QUERY_INTERRUPTED});
    // no hold without a sync command; wait holds but takes traffic
    pulse(GO, 7'h0);
    xfer(0, `ADDR_SYNC, 32'h0);
    pulse(TALK, 7'h0);
    xfer(1, `ADDR_CMD, 32'h4);
    xfer(0, `ADDR_SYNC, 32'h9);
    while (hold_exec)
      @(posedge core_clk);
    xfer(0, `ADDR_SYNC, 32'h0);
    xfer(0, `ADDR_ERRQ, 32'h0);
    results();
  end
endmodule // remote_status_sync_unit_test
`default_nettype wire

// ### verification/status_sync_monitor.sv
// Purpose: concurrent checks on the status and sync unit ports
// Assumes: bound to every remote_status_sync_unit instance
// Notes:   one clock domain, so default clocking and disable are used
`timescale 1ns/1ps
`default_nettype none
module status_sync_monitor
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // apb slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // instrument side
  input wire logic exec_busy,
  input wire logic out_buf_avail,
  input wire logic out_data_pending,
  input wire logic talker_addressed,
  input wire logic query_abort,
  input wire logic serial_poll,
  // results
  input wire logic srq,
  input wire logic ist,
  input wire logic hold_exec,
  input wire logic opc_reply
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  // every result is clear on the first edge after reset
  property p_rst_clear;
    $fell(sys_rst) |-> !srq && !ist && !hold_exec && !opc_reply;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("outputs not clear after reset");
  // the query answer only follows an idle edge
  property p_reply_idle;
    opc_reply |-> !$past(exec_busy);
  endproperty
  a_reply_idle: assert property (p_reply_idle)
    else $error("reply while still busy");
  // the answer only comes while processing was held
  property p_reply_held;
    opc_reply |-> $past(hold_exec);
  endproperty
  a_reply_held: assert property (p_reply_held)
    else $error("reply without a held query");
  // hold stays while the core is still settling, unless a query is aborted
  property p_wait_hold;
    hold_exec && exec_busy && !query_abort |=> hold_exec;
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("hold dropped while busy");
  // a raised request stays until the poll
  property p_srq_latch;
    srq && !serial_poll |=> srq;
  endproperty
  a_srq_latch: assert property (p_srq_latch)
    else $error("service request dropped early");
  // talking with nothing to say sends no answer
  property p_empty_talk;
    talker_addressed && !out_buf_avail && !out_data_pending && !hold_exec
      |=> !opc_reply;
  endproperty
  a_empty_talk: assert property (p_empty_talk)
    else $error("answer sent on empty talk");
  // the slave answers one cycle into the access phase
  property p_ready_next;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("apb answer late");
  // read data is zero outside the answer cycle
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside answer");
  // main scenarios reached
  c_reply: cover property (opc_reply);
  c_srq: cover property ($rose(srq));
  c_ist: cover property ($rose(ist));
endmodule // status_sync_monitor
bind remote_status_sync_unit status_sync_monitor mon_u (
  .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready),
  .exec_busy(exec_busy), .out_buf_avail(out_buf_avail),
  .out_data_pending(out_data_pending),
  .talker_addressed(talker_addressed), .query_abort(query_abort),
  .serial_poll(serial_poll), .srq(srq), .ist(ist),
  .hold_exec(hold_exec), .opc_reply(opc_reply));
`default_nettype wire
